// ---- common/clock_source_pkg.sv ----
// constants and types shared by the system clock source control block
`default_nettype none
package clock_source_pkg;
   localparam int unsigned CLK_FREQ_KHZ = 20000;
   localparam int unsigned POWER_UP_DELAY_MS = 64;
   localparam int unsigned POWER_UP_DELAY_CYCLES = POWER_UP_DELAY_MS * CLK_FREQ_KHZ;
   localparam int unsigned WARM_UP_DELAY_NS = 5000;
   // least time: round up to whole cycles
   localparam int unsigned WARM_UP_DELAY_CYCLES =
      (WARM_UP_DELAY_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   localparam int unsigned CRYSTAL_STARTUP_EDGES = 1024;
   localparam int unsigned CLOCKS_PER_INSTRUCTION = 4;
   localparam int unsigned RC_DELAY_INSTRUCTIONS = 2;
   localparam int unsigned RC_DELAY_CYCLES = RC_DELAY_INSTRUCTIONS * CLOCKS_PER_INSTRUCTION;
   localparam int unsigned TIMER_WIDTH = 21;
   localparam logic [4:0] EXT_IDLE_LIMIT = 5'h10;

   localparam logic [7:0] OSC_TRIM_ADDR = 8'h90;
   localparam logic [7:0] CLOCK_STATUS_ADDR = 8'h91;
   localparam logic [4:0] TRIM_RESET = 5'h00;
   localparam logic [4:0] TRIM_SIGN_FLIP = 5'h10;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   localparam int unsigned STAT_RUN_BIT = 0;
   localparam int unsigned STAT_STARTUP_BIT = 1;
   localparam int unsigned STAT_EXT_STOP_BIT = 2;
   localparam int unsigned STAT_SLEEP_BIT = 3;
   localparam int unsigned STAT_FAMILY_LSB = 4;
   localparam int unsigned STAT_FREQ_BIT = 6;

   typedef enum logic [2:0] {
      SRC_LOW_POWER_CRYSTAL  = 3'b000,
      SRC_STANDARD_CRYSTAL   = 3'b001,
      SRC_HIGH_SPEED_CRYSTAL = 3'b010,
      SRC_EXTERNAL_LOGIC     = 3'b011,
      SRC_INTERNAL_IO        = 3'b100,
      SRC_INTERNAL_CLKOUT    = 3'b101,
      SRC_RC_IO              = 3'b110,
      SRC_RC_CLKOUT          = 3'b111
   } clock_source_select_type;

   typedef enum logic [1:0] {
      FAMILY_CRYSTAL  = 2'b00,
      FAMILY_EXTERNAL = 2'b01,
      FAMILY_RC       = 2'b10,
      FAMILY_INTERNAL = 2'b11
   } clock_family_type;

   typedef enum logic [2:0] {
      ST_RESET    = 3'b000,
      ST_POWER_UP = 3'b001,
      ST_STARTUP  = 3'b010,
      ST_RUN      = 3'b011,
      ST_SLEEP    = 3'b100,
      ST_HELD     = 3'b101
   } clock_state_type;

   typedef struct packed {
      logic                    internal_freq_select;
      logic                    power_up_delay_enable;
      clock_source_select_type clock_source_select;
   } clock_config_type;
endpackage
`default_nettype wire

// ---- hw/pin_sync.sv ----
// three-stage synchroniser with agreement filter for an off-domain pin
`default_nettype none
module pin_sync (
   input  wire logic core_clk_in,
   input  wire logic resetn_in,
   input  wire logic pin_in,
   output logic      level_out,
   output logic      rise_out
);
   logic [2:0] stage_r;
   logic       level_r;
   logic       rise_r;

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stage_r <= 3'h0;
      end else begin
         stage_r <= {stage_r[1:0], pin_in};
      end
   end

   // only the second and third stages are looked at
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         level_r <= 1'b0;
         rise_r  <= 1'b0;
      end else begin
         rise_r <= stage_r[1] & stage_r[2] & ~level_r;
         if (stage_r[1] == stage_r[2]) begin
            level_r <= stage_r[2];
         end
      end
   end

   assign level_out = level_r;
   assign rise_out  = rise_r;
endmodule
`default_nettype wire

// ---- hw/delay_timer.sv ----
// loadable down counter that stays busy until its steps are used up
`default_nettype none
module delay_timer #(
   parameter int unsigned WIDTH = 21
) (
   input  wire logic             core_clk_in,
   input  wire logic             resetn_in,
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] load_value_in,
   input  wire logic             step_in,
   output logic                  busy_out
);
   logic [WIDTH-1:0] count_r;

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count_r <= '0;
      end else if (load_in) begin
         count_r <= load_value_in;
      end else if (step_in && (count_r != '0)) begin
         count_r <= count_r - 1'b1;
      end
   end

   assign busy_out = (count_r != '0);
endmodule
`default_nettype wire

// ---- hw/system_clock_source_control.sv ----
// system clock source sequencing, start-up delays and oscillator trim register
//
// Design decision made here: the address-and-strobe port.
`default_nettype none
// Summary of operation
// - crystal modes count 1024 pin oscillations first
// - count starts after power-up timer, and wake
// - program counter held while start-up counts
// - exit delay depends on selected clock source
// - logic clock mode frees clock output pin
// - logic clock mode skips start-up delay entirely
// - stopped logic clock halts, restart resumes intact
// - three-bit select field picks clock source
// - internal oscillator offers 4 or 8 MHz
// - trim is five-bit two's complement, rewritable
// - trim codes ordered monotonically, zero calibrated
// - trim applies at once, no completion flag
// - trim cleared only by power-on reset
module system_clock_source_control #(
   parameter int unsigned POWER_UP_CYCLES = clock_source_pkg::POWER_UP_DELAY_CYCLES,
   parameter int unsigned WARM_UP_CYCLES  = clock_source_pkg::WARM_UP_DELAY_CYCLES
) (
   input  wire logic                               core_clk_in,
   input  wire logic                               resetn_in,
   input  wire logic                               other_reset_in,
   input  wire clock_source_pkg::clock_config_type config_in,
   input  wire logic                               sleep_request_in,
   input  wire logic                               wake_event_in,
   input  wire logic                               clock_input_pin_in,
   input  wire logic [7:0]                         reg_addr_in,
   input  wire logic [7:0]                         reg_wdata_in,
   input  wire logic                               reg_write_in,
   input  wire logic                               reg_read_in,
   output logic [7:0]                              reg_rdata_out,
   output logic                                    core_run_out,
   output logic                                    pc_hold_out,
   output logic [4:0]                              trim_value_out,
   output logic [4:0]                              trim_level_out,
   output logic                                    internal_freq_8mhz_out,
   output logic                                    external_source_out,
   output logic                                    system_clock_from_pin_out,
   output logic                                    clock_output_pin_is_gpio_out,
   output logic                                    clock_output_drive_enable_out
);
   localparam int unsigned TW = clock_source_pkg::TIMER_WIDTH;
   localparam logic [TW-1:0] PWR_LOAD = TW'(POWER_UP_CYCLES);
   localparam logic [TW-1:0] WARM_LOAD = TW'(WARM_UP_CYCLES);
   localparam logic [TW-1:0] RC_LOAD = TW'(clock_source_pkg::RC_DELAY_CYCLES);
   localparam logic [TW-1:0] XTAL_LOAD = TW'(clock_source_pkg::CRYSTAL_STARTUP_EDGES);

   clock_source_pkg::clock_state_type  state_r;
   clock_source_pkg::clock_state_type  state_nxt;
   clock_source_pkg::clock_state_type  resume_st;
   clock_source_pkg::clock_config_type cfg_r;
   clock_source_pkg::clock_family_type family;

   logic [4:0]    trim_r;
   logic [4:0]    trim_level_r;
   logic [7:0]    rdata_r;
   logic [7:0]    status_byte;
   logic          run_r;
   logic          hold_r;
   logic          freq_r;
   logic          ext_src_r;
   logic          from_pin_r;
   logic          gpio_r;
   logic          drive_r;
   logic          run_ok;
   logic          pin_rise;
   logic          pwr_load;
   logic          pwr_busy;
   logic          start_load;
   logic [TW-1:0] start_value;
   logic          start_step;
   logic          start_busy;
   logic          begin_run;
   logic [4:0]    idle_cnt_r;
   logic          ext_stopped_r;
   logic          trim_write;
   logic          status_hit;
   logic          trim_hit;

   // sampled on the core clock: a crystal above a quarter of its rate is
   // undercounted, and start-up just lasts longer
   pin_sync u_pin_sync (
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .pin_in      (clock_input_pin_in),
      .level_out   (),
      .rise_out    (pin_rise)
   );

   delay_timer #(
      .WIDTH (TW)
   ) u_power_up_delay_timer (
      .core_clk_in   (core_clk_in),
      .resetn_in     (resetn_in),
      .load_in       (pwr_load),
      .load_value_in (PWR_LOAD),
      .step_in       (1'b1),
      .busy_out      (pwr_busy)
   );

   delay_timer #(
      .WIDTH (TW)
   ) u_crystal_startup_counter (
      .core_clk_in   (core_clk_in),
      .resetn_in     (resetn_in),
      .load_in       (start_load),
      .load_value_in (start_value),
      .step_in       (start_step),
      .busy_out      (start_busy)
   );

   // configuration is caught in the first cycle after reset release
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_r <= '0;
      end else if (state_r == clock_source_pkg::ST_RESET) begin
         cfg_r <= config_in;
      end
   end

   // source family from the three-bit select field
   always_comb begin
      case (cfg_r.clock_source_select)
         clock_source_pkg::SRC_LOW_POWER_CRYSTAL,
         clock_source_pkg::SRC_STANDARD_CRYSTAL,
         clock_source_pkg::SRC_HIGH_SPEED_CRYSTAL: begin
            family = clock_source_pkg::FAMILY_CRYSTAL;
         end
         clock_source_pkg::SRC_EXTERNAL_LOGIC: begin
            family = clock_source_pkg::FAMILY_EXTERNAL;
         end
         clock_source_pkg::SRC_RC_IO,
         clock_source_pkg::SRC_RC_CLKOUT: begin
            family = clock_source_pkg::FAMILY_RC;
         end
         default: begin
            family = clock_source_pkg::FAMILY_INTERNAL;
         end
      endcase
   end

   // start-up length and what advances it
   always_comb begin
      case (family)
         clock_source_pkg::FAMILY_CRYSTAL: begin
            start_value = XTAL_LOAD;
            start_step  = pin_rise;
         end
         clock_source_pkg::FAMILY_RC: begin
            start_value = RC_LOAD;
            start_step  = 1'b1;
         end
         clock_source_pkg::FAMILY_INTERNAL: begin
            start_value = WARM_LOAD;
            start_step  = 1'b1;
         end
         default: begin
            start_value = '0;
            start_step  = 1'b0;
         end
      endcase
   end

   // logic clock mode goes straight to run with no start-up counter, after the power-up timer if enabled
   assign begin_run = (family == clock_source_pkg::FAMILY_EXTERNAL);
   // power-up end, wake and warm-reset release share one exit delay
   assign resume_st = begin_run ? clock_source_pkg::ST_RUN : clock_source_pkg::ST_STARTUP;

   always_comb begin
      state_nxt  = state_r;
      pwr_load   = 1'b0;
      start_load = 1'b0;
      case (state_r)
         clock_source_pkg::ST_RESET: begin
            pwr_load  = config_in.power_up_delay_enable;
            state_nxt = clock_source_pkg::ST_POWER_UP;
         end
         clock_source_pkg::ST_POWER_UP: begin
            if (!pwr_busy) begin
               start_load = !begin_run;
               state_nxt  = resume_st;
            end
         end
         clock_source_pkg::ST_STARTUP: begin
            if (!start_busy) begin
               state_nxt = clock_source_pkg::ST_RUN;
            end
         end
         clock_source_pkg::ST_RUN: begin
            if (sleep_request_in) begin
               state_nxt = clock_source_pkg::ST_SLEEP;
            end
         end
         clock_source_pkg::ST_SLEEP: begin
            if (wake_event_in) begin
               start_load = !begin_run;
               state_nxt  = resume_st;
            end
         end
         clock_source_pkg::ST_HELD: begin
            if (!other_reset_in) begin
               start_load = !begin_run;
               state_nxt  = resume_st;
            end
         end
         default: begin
            state_nxt = clock_source_pkg::ST_RESET;
         end
      endcase
      // warm reset holds the core; the power-up timer never reruns
      if (other_reset_in && (state_r != clock_source_pkg::ST_RESET)
          && (state_r != clock_source_pkg::ST_POWER_UP)) begin
         state_nxt  = clock_source_pkg::ST_HELD;
         start_load = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= clock_source_pkg::ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // a stalled logic clock halts the core; state is untouched,
   // so the next edge resumes where it stopped
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         idle_cnt_r    <= 5'h00;
         ext_stopped_r <= 1'b0;
      end else if (family != clock_source_pkg::FAMILY_EXTERNAL) begin
         idle_cnt_r    <= 5'h00;
         ext_stopped_r <= 1'b0;
      end else if (pin_rise) begin
         idle_cnt_r    <= 5'h00;
         ext_stopped_r <= 1'b0;
      end else if (idle_cnt_r == clock_source_pkg::EXT_IDLE_LIMIT) begin
         ext_stopped_r <= 1'b1;
      end else begin
         idle_cnt_r <= idle_cnt_r + 5'h01;
      end
   end

   // execution gating seen by the core
   assign run_ok = (state_r == clock_source_pkg::ST_RUN) && !ext_stopped_r && !other_reset_in;
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run_r  <= 1'b0;
         hold_r <= 1'b1;
      end else begin
         run_r  <= run_ok;
         hold_r <= !run_ok;
      end
   end

   // pin and source steering follow the captured configuration
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         freq_r     <= 1'b0;
         ext_src_r  <= 1'b0;
         from_pin_r <= 1'b0;
         gpio_r     <= 1'b0;
         drive_r    <= 1'b0;
      end else begin
         freq_r     <= cfg_r.internal_freq_select;
         ext_src_r  <= (family != clock_source_pkg::FAMILY_INTERNAL);
         from_pin_r <= (family != clock_source_pkg::FAMILY_INTERNAL);
         gpio_r     <= cfg_r.clock_source_select inside {clock_source_pkg::SRC_EXTERNAL_LOGIC,
                       clock_source_pkg::SRC_INTERNAL_IO, clock_source_pkg::SRC_RC_IO};
         drive_r    <= cfg_r.clock_source_select inside {clock_source_pkg::SRC_INTERNAL_CLKOUT,
                       clock_source_pkg::SRC_RC_CLKOUT};
      end
   end

   assign trim_hit   = (reg_addr_in == clock_source_pkg::OSC_TRIM_ADDR);
   assign status_hit = (reg_addr_in == clock_source_pkg::CLOCK_STATUS_ADDR);
   assign trim_write = reg_write_in && trim_hit;

   // only power-on or brown-out reset clears the trim;
   // a warm reset on other_reset_in leaves it alone
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         trim_r <= clock_source_pkg::TRIM_RESET;
      end else if (trim_write) begin
         trim_r <= reg_wdata_in[4:0];
      end
   end

   // offset binary: a sign flip gives a monotonic 0..31 scale
   // with code 00000 at midpoint 16
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         trim_level_r <= clock_source_pkg::TRIM_RESET ^ clock_source_pkg::TRIM_SIGN_FLIP;
      end else if (trim_write) begin
         trim_level_r <= reg_wdata_in[4:0] ^ clock_source_pkg::TRIM_SIGN_FLIP;
      end
   end

   // sequencing view for software; writes to it are ignored
   always_comb begin
      status_byte = 8'h00;
      status_byte[clock_source_pkg::STAT_RUN_BIT] = run_r;
      status_byte[clock_source_pkg::STAT_STARTUP_BIT] =
         (state_r == clock_source_pkg::ST_POWER_UP) || (state_r == clock_source_pkg::ST_STARTUP);
      status_byte[clock_source_pkg::STAT_EXT_STOP_BIT] = ext_stopped_r;
      status_byte[clock_source_pkg::STAT_SLEEP_BIT] = (state_r == clock_source_pkg::ST_SLEEP);
      status_byte[clock_source_pkg::STAT_FAMILY_LSB +: 2] = family;
      status_byte[clock_source_pkg::STAT_FREQ_BIT] = freq_r;
   end

   // read data stand for one cycle only and are zero otherwise
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_r <= clock_source_pkg::RDATA_IDLE;
      end else if (reg_read_in && trim_hit) begin
         rdata_r <= {3'h0, trim_r};
      end else if (reg_read_in && status_hit) begin
         rdata_r <= status_byte;
      end else begin
         rdata_r <= clock_source_pkg::RDATA_IDLE;
      end
   end

   assign reg_rdata_out                 = rdata_r;
   assign core_run_out                  = run_r;
   assign pc_hold_out                   = hold_r;
   assign trim_value_out                = trim_r;
   assign trim_level_out                = trim_level_r;
   assign internal_freq_8mhz_out        = freq_r;
   assign external_source_out           = ext_src_r;
   assign system_clock_from_pin_out     = from_pin_r;
   assign clock_output_pin_is_gpio_out  = gpio_r;
   assign clock_output_drive_enable_out = drive_r;
endmodule
`default_nettype wire

// ---- verification/system_clock_source_control_assertions.sv ----
// concurrent checks on the ports of the clock source control block
`default_nettype none
module system_clock_source_control_assertions #(
   parameter type cfg_type = clock_source_pkg::clock_config_type
) (
   input wire logic       core_clk_in,
   input wire logic       resetn_in,
   input wire cfg_type    config_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_write_in,
   input wire logic       reg_read_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       core_run_out,
   input wire logic       pc_hold_out,
   input wire logic [4:0] trim_value_out,
   input wire logic [4:0] trim_level_out,
   input wire logic       internal_freq_8mhz_out,
   input wire logic       external_source_out,
   input wire logic       system_clock_from_pin_out,
   input wire logic       clock_output_pin_is_gpio_out,
   input wire logic       clock_output_drive_enable_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   logic [1:0] age_r;
   logic       trim_wr;
   logic       trim_rd;
   assign trim_wr = reg_write_in && reg_addr_in == clock_source_pkg::OSC_TRIM_ADDR;
   assign trim_rd = reg_read_in && reg_addr_in == clock_source_pkg::OSC_TRIM_ADDR;
   // steering settles two edges after reset
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end
   property p_hold_inverse;
      pc_hold_out == !core_run_out;
   endproperty
   a_hold_inverse: assert property (p_hold_inverse)
      else $error("pc hold is not the inverse of run");
   property p_level_map;
      trim_level_out == (trim_value_out ^ 5'h10);
   endproperty
   a_level_map: assert property (p_level_map)
      else $error("trim level mapping wrong");
   property p_trim_write;
      trim_wr |=> trim_value_out == $past(reg_wdata_in[4:0]);
   endproperty
   a_trim_write: assert property (p_trim_write)
      else $error("trim write not taken");
   property p_trim_kept;
      !trim_wr |=> $stable(trim_value_out);
   endproperty
   a_trim_kept: assert property (p_trim_kept)
      else $error("trim changed without a write");
   property p_trim_read;
      trim_rd |=> reg_rdata_out == {3'h0, $past(trim_value_out)};
   endproperty
   a_trim_read: assert property (p_trim_read)
      else $error("trim read data wrong");
   property p_rdata_idle;
      !reg_read_in |=> reg_rdata_out == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not idle");
   property p_logic_pins;
      age_r == 2'h3 && config_in.clock_source_select == clock_source_pkg::SRC_EXTERNAL_LOGIC
         |-> system_clock_from_pin_out && clock_output_pin_is_gpio_out
             && !clock_output_drive_enable_out;
   endproperty
   a_logic_pins: assert property (p_logic_pins)
      else $error("logic clock pin steering wrong");
   property p_family;
      age_r == 2'h3 |-> external_source_out == (config_in.clock_source_select[2:1] != 2'b10);
   endproperty
   a_family: assert property (p_family)
      else $error("source family wrong");
   property p_freq;
      age_r == 2'h3 |-> internal_freq_8mhz_out == config_in.internal_freq_select;
   endproperty
   a_freq: assert property (p_freq)
      else $error("frequency select wrong");
endmodule
`default_nettype wire

// ---- verification/clock_source_partner.sv ----
// behavioural crystal or logic clock source on the clock input pin
`default_nettype none
module clock_source_partner #(
   parameter int unsigned HALF_NS = 140
) (
   input  wire logic run_in,
   output logic      pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // period is no multiple of the core clock, so phase drifts
   initial begin
      pin_out = 1'b0;
      forever begin
         #(HALF_NS);
         pin_out = run_in ? ~pin_out : 1'b0; // a stopped source parks low
      end
   end
endmodule
`default_nettype wire

// ---- verification/tb_system_clock_source_control.sv ----
// self-checking bench for the system clock source control block
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_system_clock_source_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] TRIM_A = clock_source_pkg::OSC_TRIM_ADDR;
   clock_source_pkg::clock_config_type config_in = 5'h00;
   logic       core_clk_in = 1'b0;
   logic       resetn_in = 1'b0;
   logic       other_reset_in = 1'b0;
   logic       sleep_request_in = 1'b0;
   logic       wake_event_in = 1'b0;
   logic       clock_input_pin_in;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic       reg_write_in = 1'b0;
   logic       reg_read_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic       core_run_out;
   logic       pc_hold_out;
   logic [4:0] trim_value_out;
   logic [4:0] trim_level_out;
   logic       internal_freq_8mhz_out;
   logic       external_source_out;
   logic       system_clock_from_pin_out;
   logic       clock_output_pin_is_gpio_out;
   logic       clock_output_drive_enable_out;
   logic       run_src = 1'b1;
   int         edges = 0;
   int         error_cnt = 0;
   int         cmp_count = 0;
   system_clock_source_control #(.POWER_UP_CYCLES(120), .WARM_UP_CYCLES(20))
      system_clock_source_control_i (.core_clk_in, .resetn_in, .other_reset_in, .config_in,
      .sleep_request_in, .wake_event_in, .clock_input_pin_in, .reg_addr_in, .reg_wdata_in,
      .reg_write_in, .reg_read_in, .reg_rdata_out, .core_run_out, .pc_hold_out,
      .trim_value_out, .trim_level_out, .internal_freq_8mhz_out, .external_source_out,
      .system_clock_from_pin_out, .clock_output_pin_is_gpio_out,
      .clock_output_drive_enable_out);
   clock_source_partner clock_source_partner_i (.run_in(run_src), .pin_out(clock_input_pin_in));
   initial begin
      forever #25 core_clk_in = ~core_clk_in;
   end
   always @(posedge clock_input_pin_in) edges++;
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic do_reset(input logic [2:0] sel, input logic freq, input logic pwr);
      @(posedge core_clk_in);
      resetn_in <= 1'b0;
      config_in <= {freq, pwr, sel};
      repeat (6) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      edges = 0;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge core_clk_in);
      reg_write_in <= 1'b0;
      #1;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge core_clk_in);
      reg_read_in <= 1'b0;
      #1;
      d = reg_rdata_out;
      @(posedge core_clk_in);
      #1;
      `CHK("rdata after one cycle", 8'h00, reg_rdata_out)
   endtask
   task automatic strobe(input logic wake);
      @(posedge core_clk_in);
      sleep_request_in <= !wake;
      wake_event_in <= wake;
      @(posedge core_clk_in);
      sleep_request_in <= 1'b0;
      wake_event_in <= 1'b0;
   endtask
   task automatic wait_run(input logic v, input int lim, output int n);
      n = 0;
      while (core_run_out !== v && n < lim) begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
   endtask
   task automatic t_crystal(input logic [2:0] sel);
      int n;
      do_reset(sel, 1'b0, 1'b1);
      // power-up edges do not count, so 1040 is still early
      wait (edges >= 1040);
      `CHK("held during count", 1'b1, pc_hold_out)
      wait_run(1'b1, 400, n);
      `CHK("run after count", 1'b1, core_run_out)
      strobe(1'b0);
      wait_run(1'b0, 5, n);
      strobe(1'b1);
      edges = 0;
      wait (edges >= 1022);
      `CHK("held on wake", 1'b1, pc_hold_out)
      wait_run(1'b1, 400, n);
      `CHK("run after wake", 1'b1, core_run_out)
      $display("crystal test %0d done", sel);
   endtask
   task automatic t_delay(input logic [2:0] sel, input logic freq, input int d);
      int n;
      do_reset(sel, freq, 1'b0);
      wait_run(1'b1, 60, n);
      `CHK("start delay", 1'b1, n >= d + 2 && n <= d + 6)
      `CHK("pin as gpio", sel == 3'h3 || sel == 3'h4 || sel == 3'h6,
           clock_output_pin_is_gpio_out)
      `CHK("clock out drive", sel == 3'h5 || sel == 3'h7, clock_output_drive_enable_out)
      `CHK("external family", sel[2:1] != 2'b10, external_source_out)
      `CHK("clock from pin", sel[2:1] != 2'b10, system_clock_from_pin_out)
      `CHK("freq select", freq, internal_freq_8mhz_out)
      $display("delay test %0d done", sel);
   endtask
   task automatic t_logic();
      int         n;
      logic [7:0] d;
      strobe(1'b0);
      wait_run(1'b0, 5, n);
      strobe(1'b1);
      wait_run(1'b1, 8, n);
      `CHK("no wake delay", 1'b1, n <= 4)
      bus_wr(TRIM_A, 8'h0a);
      run_src = 1'b0;
      wait_run(1'b0, 40, n);
      `CHK("halts when stopped", 1'b0, core_run_out)
      bus_rd(8'h91, d);
      `CHK("status stopped", 8'h54, d)
      run_src = 1'b1;
      wait_run(1'b1, 40, n);
      `CHK("resumes", 1'b1, core_run_out)
      bus_rd(TRIM_A, d);
      `CHK("data kept over stop", 8'h0a, d)
      $display("logic clock test done");
   endtask
   task automatic t_trim();
      int         n;
      logic [7:0] d;
      logic [4:0] codes [4] = '{5'h0f, 5'h00, 5'h10, 5'h1f};
      bus_rd(TRIM_A, d);
      `CHK("trim after power-on", 8'h00, d)
      foreach (codes[i]) begin
         bus_wr(TRIM_A, {3'h7, codes[i]});
         `CHK("trim out", codes[i], trim_value_out)
         `CHK("trim level", codes[i] ^ 5'h10, trim_level_out)
         bus_rd(TRIM_A, d);
         `CHK("trim readback", {3'h0, codes[i]}, d)
      end
      `CHK("runs while tuning", 1'b1, core_run_out)
      bus_wr(8'h91, 8'h05);
      bus_rd(8'h55, d);
      `CHK("unmapped read", 8'h00, d)
      `CHK("trim untouched", 5'h1f, trim_value_out)
      @(posedge core_clk_in);
      other_reset_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      other_reset_in <= 1'b0;
      #1;
      `CHK("warm reset halts", 1'b0, core_run_out)
      wait_run(1'b1, 60, n);
      `CHK("warm reset keeps trim", 5'h1f, trim_value_out)
      do_reset(3'h4, 1'b1, 1'b0);
      #1;
      `CHK("power-on clears trim", 5'h00, trim_value_out)
      $display("trim test done");
   endtask
   initial begin
      #(80000 * 50);
      error_cnt++;
      $display("watchdog expired");
      finish_test();
   end
   initial begin
      t_crystal(3'h0);
      t_crystal(3'h1);
      t_crystal(3'h2);
      t_delay(3'h3, 1'b1, 0);
      t_logic();
      t_delay(3'h5, 1'b0, 20);
      t_delay(3'h6, 1'b0, 8);
      t_delay(3'h7, 1'b1, 8);
      t_delay(3'h4, 1'b1, 20);
      t_trim();
      finish_test();
   end
endmodule
bind system_clock_source_control system_clock_source_control_assertions chk_i (
   .core_clk_in, .resetn_in, .config_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
   .reg_read_in, .reg_rdata_out, .core_run_out, .pc_hold_out, .trim_value_out,
   .trim_level_out, .internal_freq_8mhz_out, .external_source_out,
   .system_clock_from_pin_out, .clock_output_pin_is_gpio_out, .clock_output_drive_enable_out);
`default_nettype wire
